// >>> design/mbou_consts.svh
`ifndef MBOU_CONSTS_SVH
`define MBOU_CONSTS_SVH

// Barrier type field
`define MBOU_STYPE_W 5
`define MBOU_STYPE_FULL 5'h00
`define MBOU_STYPE_ST_ST 5'h04
`define MBOU_STYPE_ALL_ORD 5'h10
`define MBOU_STYPE_LD_ALL 5'h11
`define MBOU_STYPE_ALL_ST 5'h12
`define MBOU_STYPE_LD_LD 5'h13

// Outstanding-operation counters
`define MBOU_CNT_W 4
`define MBOU_CNT_N 4
`define MBOU_CNT_ONE 4'h1
`define MBOU_CNT_ZERO 4'h0
`define MBOU_CNT_HIGH 4'hE
`define MBOU_IX_ORD_LD 0
`define MBOU_IX_ORD_ST 1
`define MBOU_IX_CMP_LD 2
`define MBOU_IX_CMP_ST 3

// Operation payload
`define MBOU_ADDR_W 32
`define MBOU_DATA_W 32

`endif

// >>> design/mbou_pkg.sv
`include "mbou_consts.svh"

package mbou_pkg;

    typedef enum logic [1:0] {
        MBOU_ST_IDLE = 2'h0,
        MBOU_ST_DRAIN = 2'h1,
        MBOU_ST_DONE = 2'h3
    } mbou_state_t;

    // Cache ops behave as stores, prefetches as loads
    typedef enum logic [1:0] {
        MBOU_CLS_LOAD = 2'h0,
        MBOU_CLS_STORE = 2'h1,
        MBOU_CLS_CACHEOP = 2'h2,
        MBOU_CLS_PREFETCH = 2'h3
    } mbou_cls_t;

    typedef struct packed {
        logic old_ld;
        logic old_st;
        logic yng_ld;
        logic yng_st;
        logic cmpl;
    } mbou_mask_t;

endpackage : mbou_pkg

// >>> design/mbou_cnt_if.sv
`include "mbou_consts.svh"

interface mbou_cnt_if;
    logic [`MBOU_CNT_N-1:0] inc;
    logic [`MBOU_CNT_N-1:0] dec;
    logic [`MBOU_CNT_N-1:0] zero;
    logic [`MBOU_CNT_N-1:0] high;

    modport ctl (output inc, output dec, input zero, input high);
    modport trk (input inc, input dec, output zero, output high);
endinterface : mbou_cnt_if

// >>> design/mbou_tracker.sv
`include "mbou_consts.svh"

module mbou_tracker (
    input wire logic clk,
    input wire logic rst_n,
    mbou_cnt_if.trk cnt
);

    logic [`MBOU_CNT_W-1:0] cnt_q [`MBOU_CNT_N];
    logic [`MBOU_CNT_W-1:0] cnt_d [`MBOU_CNT_N];

    genvar gi;
    generate
        for (gi = 0; gi < `MBOU_CNT_N; gi++)
        begin : g_cnt
            always_comb
            begin
                cnt_d[gi] = cnt_q[gi];
                if (cnt.inc[gi] && !cnt.dec[gi])
                    cnt_d[gi] = cnt_q[gi] + `MBOU_CNT_ONE;
                else if (!cnt.inc[gi] && cnt.dec[gi] && cnt_q[gi] != `MBOU_CNT_ZERO)
                    cnt_d[gi] = cnt_q[gi] - `MBOU_CNT_ONE;
            end

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    cnt_q[gi] <= `MBOU_CNT_ZERO;
                else
                    cnt_q[gi] <= cnt_d[gi];
            end

            assign cnt.zero[gi] = (cnt_q[gi] == `MBOU_CNT_ZERO);
            assign cnt.high[gi] = (cnt_q[gi] >= `MBOU_CNT_HIGH);
        end
    endgenerate

endmodule : mbou_tracker

// >>> design/mbou_top.sv
`include "mbou_consts.svh"

module mbou_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic bar_valid,
    input wire logic [`MBOU_STYPE_W-1:0] bar_stype,
    output logic bar_ready,
    output logic bar_done,
    input wire logic mop_valid,
    input wire logic [1:0] mop_cls,
    input wire logic mop_sync,
    input wire logic [`MBOU_ADDR_W-1:0] mop_addr,
    input wire logic [`MBOU_DATA_W-1:0] mop_wdata,
    output logic mop_ready,
    output logic hold_ld,
    output logic hold_st,
    output logic lsd_valid,
    output logic [1:0] lsd_cls,
    output logic lsd_sync,
    output logic [`MBOU_ADDR_W-1:0] lsd_addr,
    output logic [`MBOU_DATA_W-1:0] lsd_wdata,
    input wire logic lsd_ready,
    input wire logic ev_ord_ld,
    input wire logic ev_ord_st,
    input wire logic ev_ld_done,
    input wire logic ev_st_gp
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_s1_q;
    logic rst_s2_q;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoding

    function automatic mbou_pkg::mbou_mask_t stype_mask(input logic [`MBOU_STYPE_W-1:0] st);
        mbou_pkg::mbou_mask_t m;
        m = '{old_ld: 1'b1, old_st: 1'b1, yng_ld: 1'b1, yng_st: 1'b1, cmpl: 1'b1};
        case (st)
            `MBOU_STYPE_ST_ST: m = '{old_ld: 1'b0, old_st: 1'b1, yng_ld: 1'b0, yng_st: 1'b1, cmpl: 1'b0};
            `MBOU_STYPE_ALL_ORD: m = '{old_ld: 1'b1, old_st: 1'b1, yng_ld: 1'b1, yng_st: 1'b1, cmpl: 1'b0};
            `MBOU_STYPE_LD_ALL: m = '{old_ld: 1'b1, old_st: 1'b0, yng_ld: 1'b1, yng_st: 1'b1, cmpl: 1'b0};
            `MBOU_STYPE_ALL_ST: m = '{old_ld: 1'b1, old_st: 1'b1, yng_ld: 1'b0, yng_st: 1'b1, cmpl: 1'b0};
            `MBOU_STYPE_LD_LD: m = '{old_ld: 1'b1, old_st: 1'b0, yng_ld: 1'b1, yng_st: 1'b0, cmpl: 1'b0};
            default: m = m;
        endcase
        return m;
    endfunction : stype_mask

    // Prefetches count as loads, cache ops as stores
    function automatic logic cls_is_store(input logic [1:0] c);
        return (c == mbou_pkg::MBOU_CLS_STORE) || (c == mbou_pkg::MBOU_CLS_CACHEOP);
    endfunction : cls_is_store

    ////////////////////////////////////////////////////////////////////////////
    // Outstanding counters

    mbou_cnt_if cnt ();

    mbou_tracker u_tracker (
        .clk(mclk),
        .rst_n(rst_s2_q),
        .cnt(cnt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Barrier sequencing and op gate

    mbou_pkg::mbou_state_t state_q;
    mbou_pkg::mbou_state_t state_d;
    mbou_pkg::mbou_mask_t mask_q;
    mbou_pkg::mbou_mask_t mask_d;
    logic bar_ready_q;
    logic bar_ready_d;
    logic bar_done_q;
    logic bar_done_d;
    logic hold_ld_q;
    logic hold_ld_d;
    logic hold_st_q;
    logic hold_st_d;
    logic mop_ready_q;
    logic mop_ready_d;
    logic lsd_valid_q;
    logic lsd_valid_d;
    logic [1:0] lsd_cls_q;
    logic [1:0] lsd_cls_d;
    logic lsd_sync_q;
    logic lsd_sync_d;
    logic [`MBOU_ADDR_W-1:0] lsd_addr_q;
    logic [`MBOU_ADDR_W-1:0] lsd_addr_d;
    logic [`MBOU_DATA_W-1:0] lsd_wdata_q;
    logic [`MBOU_DATA_W-1:0] lsd_wdata_d;
    logic op_st;
    logic op_take;
    logic older_clear;

    always_comb
    begin
        op_st = cls_is_store(mop_cls);
        // Unordered access types never see the hold; synced prefetches are held by hold_ld
        op_take = mop_valid && mop_ready_q &&
                  !(mop_sync && (op_st ? hold_st_q : hold_ld_q));

        cnt.inc = '0;
        if (op_take && mop_sync)
        begin
            cnt.inc[`MBOU_IX_ORD_LD] = !op_st;
            cnt.inc[`MBOU_IX_ORD_ST] = op_st;
            cnt.inc[`MBOU_IX_CMP_LD] = !op_st;
            cnt.inc[`MBOU_IX_CMP_ST] = op_st;
        end
        cnt.dec[`MBOU_IX_ORD_LD] = ev_ord_ld;
        cnt.dec[`MBOU_IX_ORD_ST] = ev_ord_st;
        cnt.dec[`MBOU_IX_CMP_LD] = ev_ld_done;
        cnt.dec[`MBOU_IX_CMP_ST] = ev_st_gp;

        // Completion waits on performed counts; ordering only on the ordering point
        if (mask_q.cmpl)
            older_clear = (!mask_q.old_ld || cnt.zero[`MBOU_IX_CMP_LD]) &&
                          (!mask_q.old_st || cnt.zero[`MBOU_IX_CMP_ST]);
        else
            older_clear = (!mask_q.old_ld || cnt.zero[`MBOU_IX_ORD_LD]) &&
                          (!mask_q.old_st || cnt.zero[`MBOU_IX_ORD_ST]);

        state_d = state_q;
        mask_d = mask_q;
        case (state_q)
            mbou_pkg::MBOU_ST_IDLE:
            begin
                if (bar_valid && bar_ready_q)
                begin
                    mask_d = stype_mask(bar_stype);
                    state_d = mbou_pkg::MBOU_ST_DRAIN;
                end
            end
            mbou_pkg::MBOU_ST_DRAIN:
            begin
                if (older_clear)
                    state_d = mbou_pkg::MBOU_ST_DONE;
            end
            mbou_pkg::MBOU_ST_DONE:
                state_d = mbou_pkg::MBOU_ST_IDLE;
            default:
                state_d = mbou_pkg::MBOU_ST_IDLE;
        endcase

        bar_ready_d = (state_d == mbou_pkg::MBOU_ST_IDLE) && !(bar_valid && bar_ready_q);
        bar_done_d = (state_d == mbou_pkg::MBOU_ST_DONE);
        hold_ld_d = (state_d == mbou_pkg::MBOU_ST_DRAIN) && mask_d.yng_ld;
        hold_st_d = (state_d == mbou_pkg::MBOU_ST_DRAIN) && mask_d.yng_st;

        // Single-entry stage towards the datapath keeps issue strictly in order
        lsd_valid_d = lsd_valid_q;
        lsd_cls_d = lsd_cls_q;
        lsd_sync_d = lsd_sync_q;
        lsd_addr_d = lsd_addr_q;
        lsd_wdata_d = lsd_wdata_q;
        if (lsd_valid_q && lsd_ready)
            lsd_valid_d = 1'b0;
        if (op_take)
        begin
            lsd_valid_d = 1'b1;
            lsd_cls_d = mop_cls;
            lsd_sync_d = mop_sync;
            lsd_addr_d = mop_addr;
            lsd_wdata_d = mop_wdata;
        end
        // Ready is registered, so refuse a cycle early near counter limit
        mop_ready_d = !lsd_valid_d && !(|cnt.high);
    end

    always_ff @(posedge mclk or negedge rst_s2_q)
    begin
        if (!rst_s2_q)
        begin
            state_q <= mbou_pkg::MBOU_ST_IDLE;
            mask_q <= '0;
            bar_ready_q <= 1'b0;
            bar_done_q <= 1'b0;
            hold_ld_q <= 1'b0;
            hold_st_q <= 1'b0;
            mop_ready_q <= 1'b0;
            lsd_valid_q <= 1'b0;
            lsd_cls_q <= 2'h0;
            lsd_sync_q <= 1'b0;
            lsd_addr_q <= '0;
            lsd_wdata_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            mask_q <= mask_d;
            bar_ready_q <= bar_ready_d;
            bar_done_q <= bar_done_d;
            hold_ld_q <= hold_ld_d;
            hold_st_q <= hold_st_d;
            mop_ready_q <= mop_ready_d;
            lsd_valid_q <= lsd_valid_d;
            lsd_cls_q <= lsd_cls_d;
            lsd_sync_q <= lsd_sync_d;
            lsd_addr_q <= lsd_addr_d;
            lsd_wdata_q <= lsd_wdata_d;
        end
    end

    assign bar_ready = bar_ready_q;
    assign bar_done = bar_done_q;
    assign hold_ld = hold_ld_q;
    assign hold_st = hold_st_q;
    assign mop_ready = mop_ready_q;
    assign lsd_valid = lsd_valid_q;
    assign lsd_cls = lsd_cls_q;
    assign lsd_sync = lsd_sync_q;
    assign lsd_addr = lsd_addr_q;
    assign lsd_wdata = lsd_wdata_q;

endmodule : mbou_top

// >>> dv/mbou_assertions.sv
`include "mbou_consts.svh"

module mbou_assertions (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic bar_valid,
    input wire logic [`MBOU_STYPE_W-1:0] bar_stype,
    input wire logic bar_ready,
    input wire logic bar_done,
    input wire logic mop_valid,
    input wire logic [1:0] mop_cls,
    input wire logic mop_sync,
    input wire logic mop_ready,
    input wire logic hold_ld,
    input wire logic hold_st,
    input wire logic lsd_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic tk;
    logic go;
    logic lite;
    assign tk = bar_valid && bar_ready;
    assign go = mop_valid && mop_ready && !(mop_sync && ((mop_cls inside {2'h1, 2'h2}) ? hold_st : hold_ld));
    // Types with a lighter behaviour of their own
    assign lite = bar_stype inside {`MBOU_STYPE_ST_ST, [`MBOU_STYPE_ALL_ORD:`MBOU_STYPE_LD_LD]};
    a_done_pulse: assert property (bar_done |=> !bar_done)
        else $error("done too long");
    a_take_busy: assert property (tk |=> !bar_ready ##1 !bar_ready)
        else $error("ready after take");
    a_done_ready: assert property (bar_done |=> bar_ready)
        else $error("no ready after done");
    a_full_hold: assert property (tk && bar_stype == `MBOU_STYPE_FULL |=> hold_ld && hold_st)
        else $error("type zero hold");
    a_other_full: assert property (tk && !lite |=> hold_ld && hold_st)
        else $error("unassigned hold");
    a_st_only: assert property (tk && bar_stype == `MBOU_STYPE_ST_ST |=> hold_st && !hold_ld)
        else $error("store fence hold");
    a_ld_only: assert property (tk && bar_stype == `MBOU_STYPE_LD_LD |=> hold_ld && !hold_st)
        else $error("load fence hold");
    a_op_fwd: assert property (go |=> lsd_valid)
        else $error("op not staged");
    a_retire_free: assert property (bar_done |-> !hold_ld && !hold_st)
        else $error("hold at retire");
endmodule : mbou_assertions

////////////////////////////////////////////////////////////////
bind mbou_top mbou_assertions u_chk (.mclk, .rst_n, .bar_valid, .bar_stype, .bar_ready, .bar_done,
    .mop_valid, .mop_cls, .mop_sync, .mop_ready, .hold_ld, .hold_st, .lsd_valid);

// >>> dv/mbou_lsd_model.sv
module mbou_lsd_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic lsd_valid,
    input wire logic [1:0] lsd_cls,
    input wire logic lsd_sync,
    output logic lsd_ready,
    output logic ev_ord_ld,
    output logic ev_ord_st,
    output logic ev_ld_done,
    output logic ev_st_gp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ld_q;
    logic [7:0] st_q;
    logic tick_q;
    logic acc;
    // Slow mode stalls every other cycle
    assign lsd_ready = !slow || tick_q;
    assign acc = lsd_valid && lsd_ready && lsd_sync;
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            {tick_q, ld_q, st_q} <= 17'h00000;
        else
        begin
            tick_q <= !tick_q;
            // One in-order pipe for loads and one for stores, so older stays ahead
            ld_q <= {ld_q[6:0], acc && lsd_cls inside {2'h0, 2'h3}};
            st_q <= {st_q[6:0], acc && lsd_cls inside {2'h1, 2'h2}};
        end
    assign ev_ord_ld = ld_q[0];
    assign ev_ord_st = st_q[0];
    assign ev_ld_done = ld_q[7];
    assign ev_st_gp = st_q[7];
endmodule : mbou_lsd_model

// >>> dv/memory_barrier_ordering_unit_tb.sv
`include "mbou_consts.svh"

module memory_barrier_ordering_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst_n = 1'b0, slow = 1'b0, bar_valid = 1'b0, mop_valid = 1'b0, mop_sync = 1'b0;
    logic [`MBOU_STYPE_W-1:0] bar_stype = 5'h00;
    logic [1:0] mop_cls = 2'h0, lsd_cls;
    logic [31:0] mop_addr = 32'h00000000, lsd_addr, lsd_wdata;
    logic bar_ready, bar_done, mop_ready, hold_ld, hold_st, lsd_valid, lsd_sync, lsd_ready;
    logic ev_ord_ld, ev_ord_st, ev_ld_done, ev_st_gp, gp_seen, ld_seen;
    int fail_count = 0, checked = 0, done_n = 0;
    mbou_top DUT (.mclk, .rst_n, .bar_valid, .bar_stype, .bar_ready, .bar_done, .mop_valid, .mop_cls,
        .mop_sync, .mop_addr, .mop_wdata(~mop_addr), .mop_ready, .hold_ld, .hold_st, .lsd_valid, .lsd_cls,
        .lsd_sync, .lsd_addr, .lsd_wdata, .lsd_ready, .ev_ord_ld, .ev_ord_st, .ev_ld_done, .ev_st_gp);
    mbou_lsd_model PEER (.mclk, .rst_n, .slow, .lsd_valid, .lsd_cls, .lsd_sync, .lsd_ready, .ev_ord_ld,
        .ev_ord_st, .ev_ld_done, .ev_st_gp);
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk)
    begin
        gp_seen = gp_seen | ev_st_gp;
        ld_seen = ld_seen | ev_ld_done;
        done_n = done_n + (bar_done === 1'b1);
    end
    ////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    function automatic logic [1:0] want(input logic [4:0] t);
        case (t)
            `MBOU_STYPE_ST_ST, `MBOU_STYPE_ALL_ST: want = 2'h1;
            `MBOU_STYPE_LD_LD: want = 2'h2;
            default: want = 2'h3;
        endcase
    endfunction : want
    // Held ops stay presented until taken
    task automatic put(input logic [1:0] c, input logic s, input logic [31:0] a);
        @(negedge mclk);
        {mop_valid, mop_cls, mop_sync, mop_addr} = {1'b1, c, s, a};
        for (int n = 0; n < 80 && !(mop_ready === 1'b1 && !(s && (c inside {2'h1, 2'h2} ? hold_st : hold_ld)));
            n++)
            @(negedge mclk);
        chk(mop_ready === 1'b1 && !(s && (c inside {2'h1, 2'h2} ? hold_st : hold_ld)), "op refused");
        @(negedge mclk);
        mop_valid = 1'b0;
    endtask : put
    task automatic bar(input logic [4:0] t);
        @(negedge mclk);
        {bar_valid, bar_stype} = {1'b1, t};
        for (int n = 0; n < 80 && bar_ready !== 1'b1; n++)
            @(negedge mclk);
        chk(bar_ready === 1'b1, "barrier refused");
        @(negedge mclk);
        bar_valid = 1'b0;
    endtask : bar
    task automatic fin();
        for (int n = 0; n < 100 && done_n == 0; n++)
            @(negedge mclk);
        chk(done_n == 1, "retire count");
        chk(bar_ready === 1'b1, "no ready after retire");
        done_n = 0;
    endtask : fin
    ////////////////////////////////////////////////////////////////
    task automatic t_types();
        logic [4:0] ts[9] = '{5'h00, 5'h04, 5'h10, 5'h11, 5'h12, 5'h13, 5'h05, 5'h14, 5'h1F};
        foreach (ts[i])
        begin
            bar(ts[i]);
            chk({hold_ld, hold_st} === want(ts[i]), "hold mask");
            fin();
        end
    endtask : t_types
    task automatic t_full();
        gp_seen = 1'b0;
        put(2'h2, 1'b1, 32'h00001000);
        bar(`MBOU_STYPE_FULL);
        chk(gp_seen === 1'b0, "gp too soon");
        put(2'h3, 1'b1, 32'h00002000);
        chk(gp_seen === 1'b1 && done_n == 1, "younger went early");
        fin();
    endtask : t_full
    task automatic t_nosync();
        gp_seen = 1'b0;
        put(2'h1, 1'b1, 32'h00003000);
        bar(`MBOU_STYPE_FULL);
        put(2'h0, 1'b0, 32'h00004000);
        chk(gp_seen === 1'b0 && lsd_valid === 1'b1 && lsd_addr === 32'h00004000, "unsynced held");
        chk(lsd_wdata === 32'hFFFFBFFF, "payload");
        chk(lsd_cls === 2'h0 && lsd_sync === 1'b0, "stage fields");
        fin();
    endtask : t_nosync
    // Slow datapath: ordering fence must not wait for writeback
    task automatic t_ord();
        ld_seen = 1'b0;
        put(2'h0, 1'b1, 32'h00005000);
        bar(`MBOU_STYPE_ALL_ORD);
        fin();
        chk(ld_seen === 1'b0, "fence waited");
    endtask : t_ord
    initial
    begin
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_types();
        t_full();
        t_nosync();
        slow = 1'b1;
        t_ord();
        stop_test();
    end
    initial
    begin
        #40000;
        fail_count++;
        stop_test();
    end
endmodule : memory_barrier_ordering_unit_tb
